// file: pkg/lag_pkg.sv
// constants and types of the logical address generation block
// How it works
// R1: physical space is bytes, 36-bit address
// R2: flat model spans 32-bit linear space
// R3: logical address converted to linear automatically
// R4: up to 16383 segments, 4 GB each
// R5: paging off drives linear address untranslated
// R6: paging on maps pages to physical frames
// R7: real model: 64 KB segments, 1 MB
// R8: real mode allows only real model
// R9: protected mode allows any model per task
// R10: management mode uses separate real-like space
// R11: 32-bit size allows full 32-bit offsets
// R12: 16-bit size limits offsets to 16 bits
// R13: far pointer is selector plus sized offset
// R14: prefixes override address and operand size
// R15: protected defaults come from code descriptor
// R16: real mode 16-bit default, 1 MB cap
// R17: reset starts in real-address mode
// R18: interrupt pin enters management mode, return restores
// R19: linear is base plus offset, wrapped
package lag_pkg;
	localparam int PHYS_W = 36;
	localparam int LIN_W = 32;
	localparam int SEL_W = 16;
	localparam int SEL_IDX_LSB = 3;
	localparam int PAGE_LSB = 12;
	localparam int FRAME_W = PHYS_W - PAGE_LSB;
	localparam int VPN_W = LIN_W - PAGE_LSB;
	localparam int REAL_SHIFT = 4;
	localparam int NUM_SEG = 16383;
	localparam logic [LIN_W-1:0] MASK32 = 32'hffffffff;
	localparam logic [LIN_W-1:0] MASK16 = 32'h0000ffff;
	localparam logic [LIN_W-1:0] MASK20 = 32'h000fffff;
	localparam logic [LIN_W-1:0] SMM_BASE_RESET = 32'h00030000;
	typedef enum logic [1:0]
	{
		LAG_MODE_REAL = 2'b00,
		LAG_MODE_PROT = 2'b01,
		LAG_MODE_SMM = 2'b10
	} lag_mode_e;
	typedef enum logic [1:0]
	{
		LAG_MODEL_FLAT = 2'b00,
		LAG_MODEL_SEG = 2'b01,
		LAG_MODEL_REAL = 2'b10
	} lag_model_e;
endpackage

// file: design/lag_size_sel.sv
// one size selector: default plus override prefix
`timescale 1ns/1ns
`default_nettype none
module lag_size_sel
(
	input wire logic defIs32,
	input wire logic overridePrefix,
	output logic is32
);
	// prefix flips the default for one instruction
	assign is32 = defIs32 ^ overridePrefix; // R14
endmodule
`default_nettype wire

// file: design/lag_page_map.sv
// page mapper: linear to physical, paging optional
`timescale 1ns/1ns
`default_nettype none
module lag_page_map
(
	input wire logic pagingOn,
	input wire logic [lag_pkg::LIN_W-1:0] linAddr,
	input wire logic [lag_pkg::FRAME_W-1:0] frameIn,
	output logic [lag_pkg::VPN_W-1:0] vpn,
	output logic [lag_pkg::PHYS_W-1:0] physAddr
);
	import lag_pkg::*;
	// page number goes out for lookup by the table walker
	assign vpn = linAddr[LIN_W-1:PAGE_LSB];
	// direct mapping zero-extends, paged mapping substitutes frame
	always_comb
	begin
		if (pagingOn)
			physAddr = {frameIn, linAddr[PAGE_LSB-1:0]}; // R6
		else
			physAddr = {{(PHYS_W-LIN_W){1'b0}}, linAddr}; // R5 R1
	end
endmodule
`default_nettype wire

// file: design/lag_top.sv
// logical address generation: mode, sizes, linear and physical address
`timescale 1ns/1ns
`default_nettype none
module lag_top
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic protEnable,
	input wire logic pagingEnable,
	input wire logic system_management_interrupt_pin,
	input wire logic local_interrupt_controller_smi,
	input wire logic smmReturn,
	input wire logic taskSwitch,
	input wire lag_pkg::lag_model_e taskModel,
	input wire logic codeDescIs32,
	input wire logic addrPrefix,
	input wire logic opPrefix,
	input wire logic reqValid,
	input wire logic [lag_pkg::SEL_W-1:0] segSelector,
	input wire logic [lag_pkg::LIN_W-1:0] segBase,
	input wire logic [lag_pkg::LIN_W-1:0] offset,
	input wire logic [lag_pkg::FRAME_W-1:0] pageFrame,
	output logic [1:0] mode,
	output logic [1:0] model,
	output logic addrIs32,
	output logic opIs32,
	output logic inSmm,
	output logic system_management_memory_sel,
	output logic addrValid,
	output logic segFault,
	output logic [lag_pkg::LIN_W-1:0] linAddr,
	output logic [lag_pkg::PHYS_W-1:0] physAddr,
	output logic [lag_pkg::VPN_W-1:0] pageNum
);
	import lag_pkg::*;

	lag_mode_e mode_ff, nxt_mode;
	lag_mode_e savedMode_ff, nxt_savedMode;
	lag_model_e model_ff, nxt_model;
	lag_model_e savedModel_ff, nxt_savedModel;
	logic smiPrev_ff, nxt_smiPrev;
	logic smiReq;
	logic smiEdge;
	logic defIs32;
	logic addr32;
	logic op32;
	logic [LIN_W-1:0] effOffset;
	logic [LIN_W-1:0] segOrigin;
	logic [LIN_W-1:0] rawLin;
	logic [LIN_W-1:0] linNext;
	logic [LIN_W-1:0] limMask;
	logic selNull;
	logic [VPN_W-1:0] vpnC;
	logic [PHYS_W-1:0] physC;
	logic [1:0] mode_o_ff, model_o_ff;
	logic addrIs32_ff, opIs32_ff, inSmm_ff, system_management_memory_ff, valid_ff, fault_ff;
	logic [LIN_W-1:0] lin_ff;
	logic [PHYS_W-1:0] phys_ff;
	logic [VPN_W-1:0] vpn_ff;
	logic [1:0] nxt_mode_o, nxt_model_o;
	logic nxt_addrIs32, nxt_opIs32, nxt_inSmm, nxt_system_management_memory, nxt_valid, nxt_fault;
	logic [LIN_W-1:0] nxt_lin;
	logic [PHYS_W-1:0] nxt_phys;
	logic [VPN_W-1:0] nxt_vpn;

	// either interrupt source requests management mode
	assign smiReq = system_management_interrupt_pin | local_interrupt_controller_smi; // R18
	assign smiEdge = smiReq & ~smiPrev_ff;

	// operating mode sequencing with context save and restore
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_savedMode = savedMode_ff;
		nxt_model = model_ff;
		nxt_savedModel = savedModel_ff;
		nxt_smiPrev = smiReq;
		case (mode_ff)
			LAG_MODE_REAL:
			begin
				nxt_model = LAG_MODEL_REAL; // R8
				if (smiEdge)
				begin
					nxt_savedMode = mode_ff; // R18
					nxt_savedModel = model_ff;
					nxt_mode = LAG_MODE_SMM; // R10
				end
				else if (protEnable)
				begin
					nxt_mode = LAG_MODE_PROT;
					nxt_model = LAG_MODEL_FLAT;
				end
			end
			LAG_MODE_PROT:
			begin
				if (smiEdge)
				begin
					nxt_savedMode = mode_ff; // R18
					nxt_savedModel = model_ff;
					nxt_mode = LAG_MODE_SMM; // R10
				end
				else if (!protEnable)
				begin
					nxt_mode = LAG_MODE_REAL;
					nxt_model = LAG_MODEL_REAL;
				end
				else if (taskSwitch)
					nxt_model = taskModel; // R9
			end
			LAG_MODE_SMM:
			begin
				nxt_model = LAG_MODEL_REAL; // R10
				if (smmReturn)
				begin
					nxt_mode = savedMode_ff; // R18
					nxt_model = savedModel_ff;
				end
			end
			default:
			begin
				nxt_mode = LAG_MODE_REAL;
				nxt_model = LAG_MODEL_REAL;
			end
		endcase
	end

	// mode registers, reset lands in real-address mode
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_ff <= LAG_MODE_REAL; // R17
			model_ff <= LAG_MODEL_REAL; // R17
			savedMode_ff <= LAG_MODE_REAL;
			savedModel_ff <= LAG_MODEL_REAL;
			smiPrev_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			model_ff <= nxt_model;
			savedMode_ff <= nxt_savedMode;
			savedModel_ff <= nxt_savedModel;
			smiPrev_ff <= nxt_smiPrev;
		end
	end

	// default size: descriptor in protected mode, 16 bits otherwise
	assign defIs32 = (mode_ff == LAG_MODE_PROT) ? codeDescIs32 : 1'b0; // R15 R16

	lag_size_sel u_addr_size
	(
		.defIs32(defIs32),
		.overridePrefix(addrPrefix),
		.is32(addr32)
	);

	lag_size_sel u_op_size
	(
		.defIs32(defIs32),
		.overridePrefix(opPrefix),
		.is32(op32)
	);

	// selector index 0 is null; 8191 usable segment indices
	assign selNull = (segSelector[SEL_W-1:SEL_IDX_LSB] == '0) && (mode_ff == LAG_MODE_PROT)
		&& (model_ff == LAG_MODEL_SEG); // R4

	// offset truncated to active address width
	assign effOffset = addr32 ? (offset & MASK32) : (offset & MASK16); // R11 R12 R13

	// segment origin per model
	always_comb
	begin
		case (model_ff)
			LAG_MODEL_FLAT: segOrigin = '0; // R2
			LAG_MODEL_SEG: segOrigin = segBase; // R3
			LAG_MODEL_REAL: segOrigin = {{(LIN_W-SEL_W-REAL_SHIFT){1'b0}}, segSelector, {REAL_SHIFT{1'b0}}}; // R7
			default: segOrigin = '0;
		endcase
	end

	// base plus offset, wrapped at 1 MB in real model, else in active width
	assign rawLin = segOrigin + effOffset; // R19
	always_comb
	begin
		if (model_ff == LAG_MODEL_REAL)
			limMask = MASK20; // R7 R16
		else if (addr32)
			limMask = MASK32; // R11
		else
			limMask = MASK16; // R12
	end
	assign linNext = rawLin & limMask;

	// paging only in protected mode, never in management space
	lag_page_map u_page
	(
		.pagingOn(pagingEnable && (mode_ff == LAG_MODE_PROT)),
		.linAddr(linNext),
		.frameIn(pageFrame),
		.vpn(vpnC),
		.physAddr(physC)
	);

	// next output values; addresses hold until the next request
	always_comb
	begin
		nxt_mode_o = mode_ff;
		nxt_model_o = model_ff;
		nxt_addrIs32 = addr32;
		nxt_opIs32 = op32;
		nxt_inSmm = (mode_ff == LAG_MODE_SMM);
		nxt_valid = reqValid && !selNull;
		nxt_fault = reqValid && selNull;
		nxt_system_management_memory = system_management_memory_ff;
		nxt_lin = lin_ff;
		nxt_phys = phys_ff;
		nxt_vpn = vpn_ff;
		if (reqValid)
		begin
			nxt_system_management_memory = (mode_ff == LAG_MODE_SMM); // R10
			nxt_lin = linNext;
			nxt_phys = physC; // R5 R6
			nxt_vpn = vpnC;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_o_ff <= LAG_MODE_REAL;
			model_o_ff <= LAG_MODEL_REAL;
			addrIs32_ff <= 1'b0;
			opIs32_ff <= 1'b0;
			inSmm_ff <= 1'b0;
			system_management_memory_ff <= 1'b0;
			valid_ff <= 1'b0;
			fault_ff <= 1'b0;
			lin_ff <= '0;
			phys_ff <= '0;
			vpn_ff <= '0;
		end
		else
		begin
			mode_o_ff <= nxt_mode_o;
			model_o_ff <= nxt_model_o;
			addrIs32_ff <= nxt_addrIs32;
			opIs32_ff <= nxt_opIs32;
			inSmm_ff <= nxt_inSmm;
			valid_ff <= nxt_valid;
			fault_ff <= nxt_fault;
			system_management_memory_ff <= nxt_system_management_memory;
			lin_ff <= nxt_lin;
			phys_ff <= nxt_phys;
			vpn_ff <= nxt_vpn;
		end
	end

	assign mode = mode_o_ff;
	assign model = model_o_ff;
	assign addrIs32 = addrIs32_ff;
	assign opIs32 = opIs32_ff;
	assign inSmm = inSmm_ff;
	assign system_management_memory_sel = system_management_memory_ff;
	assign addrValid = valid_ff;
	assign segFault = fault_ff;
	assign linAddr = lin_ff;
	assign physAddr = phys_ff;
	assign pageNum = vpn_ff;
endmodule
`default_nettype wire

// file: tb/lag_checker.sv
// assertions on the address generation ports
`timescale 1ns/1ns
`default_nettype none
module lag_checker
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic reqValid,
	input wire logic addrPrefix,
	input wire logic pagingEnable,
	input wire logic system_management_interrupt_pin,
	input wire logic smmReturn,
	input wire logic [lag_pkg::SEL_W-1:0] segSelector,
	input wire logic [lag_pkg::LIN_W-1:0] offset,
	input wire logic [1:0] mode,
	input wire logic [1:0] model,
	input wire logic addrIs32,
	input wire logic inSmm,
	input wire logic addrValid,
	input wire logic segFault,
	input wire logic [lag_pkg::LIN_W-1:0] linAddr,
	input wire logic [lag_pkg::PHYS_W-1:0] physAddr
);
	import lag_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// request answering and address mapping
	one_answer_a: assert property (reqValid |=> addrValid != segFault) else $error("no single answer");
	no_answer_a: assert property (!reqValid |=> !addrValid && !segFault) else $error("stray answer");
	direct_map_a: assert property (addrValid && !$past(pagingEnable) |-> physAddr == {4'h0, linAddr})
		else $error("paging off address translated");
	page_offset_a: assert property (addrValid |-> physAddr[11:0] == linAddr[11:0]) else $error("page offset lost");
	real_lin_a: assert property (addrValid && $past(mode) == LAG_MODE_REAL && !$past(addrPrefix) |->
		linAddr == (({$past(segSelector), 4'h0} + $past(offset[15:0])) & MASK20)) else $error("real address wrong");
	// mode and model relations
	real_model_a: assert property (mode == LAG_MODE_REAL && $past(mode) == LAG_MODE_REAL |-> model == LAG_MODEL_REAL)
		else $error("real mode with other model");
	smm_entry_a: assert property ($rose(system_management_interrupt_pin) |-> ##[1:2] inSmm) else $error("no entry");
	smm_return_a: assert property (inSmm && smmReturn |-> ##2 !inSmm) else $error("no return");
	smm_flag_a: assert property (inSmm |-> mode == LAG_MODE_SMM) else $error("flag and mode disagree");
	reset_real_a: assert property ($rose(arst_n) |-> mode == LAG_MODE_REAL && !addrIs32 && !inSmm)
		else $error("reset state wrong");
endmodule
bind lag_top lag_checker i_lag_checker(.*);
`default_nettype wire

// file: tb/lag_mem_model.sv
// page frame lookup standing in for physical memory
`timescale 1ns/1ns
`default_nettype none
module lag_mem_model
(
	input wire logic [lag_pkg::VPN_W-1:0] vpn,
	output logic [lag_pkg::FRAME_W-1:0] frame
);
	import lag_pkg::*;
	// every page lands in the upper 36-bit region
	assign frame = {4'ha, vpn};
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the logical address generation block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import lag_pkg::*;
	logic core_clk, arst_n = 1'h0, protEnable = 1'h0, pagingEnable = 1'h0, smmReturn = 1'h0, taskSwitch = 1'h0;
	logic system_management_interrupt_pin = 1'h0, local_interrupt_controller_smi = 1'h0, reqValid = 1'h0;
	logic codeDescIs32 = 1'h1, addrPrefix = 1'h0, opPrefix = 1'h0;
	lag_model_e taskModel = LAG_MODEL_FLAT;
	logic [15:0] segSelector = 16'h0;
	logic [31:0] segBase = 32'h0, offset = 32'h0;
	logic [23:0] pageFrame;
	logic [19:0] pageNum;
	logic [1:0] mode, model;
	logic addrIs32, opIs32, inSmm, system_management_memory_sel, addrValid, segFault;
	logic [31:0] linAddr;
	logic [35:0] physAddr;
	logic [31:0] walkLin;
	int bad_count = 0, samples_checked = 0;
	lag_top i_lag_top(.*);
	// table walker looks up the page of the request being taken
	assign walkLin = segBase + offset;
	lag_mem_model i_lag_mem_model(.vpn(walkLin[31:12]), .frame(pageFrame));
	// clock
	initial
	begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	// compare and count
	task chk(input string n, input logic [35:0] s, input logic [35:0] e);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	// one request, answer judged a cycle later
	task req(input logic [15:0] sel, input logic [31:0] off, input logic [31:0] e);
		@(negedge core_clk);
		segSelector = sel;
		offset = off;
		reqValid = 1'h1;
		@(negedge core_clk);
		reqValid = 1'h0;
		chk("valid", addrValid, 1'h1);
		chk("lin", linAddr, e);
		chk("phys", physAddr, pagingEnable ? {4'ha, e} : {4'h0, e});
	endtask
	// real mode walk, wrap and override cap
	task t_real;
		chk("mode", mode, LAG_MODE_REAL);
		req(16'h1234, 32'h10, 32'h12350);
		req(16'hffff, 32'hffff, 32'hffef);
		addrPrefix = 1'h1;
		req(16'hffff, 32'h100000, 32'hffff0);
		addrPrefix = 1'h0;
	endtask
	// protected flat, full and prefixed sizes
	task t_flat;
		protEnable = 1'h1;
		opPrefix = 1'h1;
		repeat (3) @(negedge core_clk);
		chk("mode", mode, LAG_MODE_PROT);
		chk("addr32", addrIs32, 1'h1);
		chk("op32", opIs32, 1'h0);
		opPrefix = 1'h0;
		req(16'h0, 32'hfedcba98, 32'hfedcba98);
		addrPrefix = 1'h1;
		req(16'h0, 32'hfedcba98, 32'hba98);
		addrPrefix = 1'h0;
	endtask
	// segmented task, base wrap and null selector
	task t_seg;
		taskModel = LAG_MODEL_SEG;
		taskSwitch = 1'h1;
		@(negedge core_clk);
		taskSwitch = 1'h0;
		repeat (2) @(negedge core_clk);
		chk("model", model, LAG_MODEL_SEG);
		segBase = 32'hfffffff0;
		req(16'h8, 32'h20, 32'h10);
		@(negedge core_clk);
		segSelector = 16'h7;
		reqValid = 1'h1;
		@(negedge core_clk);
		reqValid = 1'h0;
		chk("fault", segFault, 1'h1);
	endtask
	// paging through the memory model
	task t_page;
		pagingEnable = 1'h1;
		segBase = 32'h12345000;
		req(16'h8, 32'h678, 32'h12345678);
		chk("page", pageNum, 20'h12345);
		pagingEnable = 1'h0;
	endtask
	// management mode entry, real-like space, return
	task t_smm;
		system_management_interrupt_pin = 1'h1;
		repeat (3) @(negedge core_clk);
		chk("smm", inSmm, 1'h1);
		req(16'h1234, 32'h10, 32'h12350);
		chk("space", system_management_memory_sel, 1'h1);
		smmReturn = 1'h1;
		@(negedge core_clk);
		smmReturn = 1'h0;
		system_management_interrupt_pin = 1'h0;
		repeat (2) @(negedge core_clk);
		chk("back", {mode, model}, {LAG_MODE_PROT, LAG_MODEL_SEG});
	endtask
	// controller request enters management mode, returns to protected, then back to real
	task t_ctrl;
		local_interrupt_controller_smi = 1'h1;
		repeat (3) @(negedge core_clk);
		chk("ctrl smm", inSmm, 1'h1);
		smmReturn = 1'h1;
		@(negedge core_clk);
		smmReturn = 1'h0;
		local_interrupt_controller_smi = 1'h0;
		repeat (2) @(negedge core_clk);
		chk("ctrl back", mode, LAG_MODE_PROT);
		protEnable = 1'h0;
		repeat (3) @(negedge core_clk);
		chk("real again", {mode, model}, {LAG_MODE_REAL, LAG_MODEL_REAL});
		chk("real size", addrIs32, 1'h0);
	endtask
	// verdict
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		stop_test;
	end
	// main sequence
	initial
	begin
		repeat (2) @(negedge core_clk);
		arst_n = 1'h1;
		t_real;
		t_flat;
		t_seg;
		t_page;
		t_smm;
		t_ctrl;
		stop_test;
	end
endmodule
`default_nettype wire
